// ### sd_host_consts.vh
`ifndef SD_HOST_CONSTS_VH
`define SD_HOST_CONSTS_VH
// =====================================================================
// Register offsets (byte addresses, one 32-bit word each).
`define REG_CTRL      8'h00
`define REG_ARG       8'h04
`define REG_STATUS    8'h08
`define REG_RESP0     8'h0C
`define REG_RESP1     8'h10
`define REG_RESP2     8'h14
`define REG_RESP3     8'h18
`define REG_CLKDIV    8'h1C
// =====================================================================
// Control register fields.
`define CTRL_IDX_LSB  0
`define CTRL_START    8
`define CTRL_RESP_EN  9
`define CTRL_BUSY_EN  10
`define CTRL_LONG     11
`define CTRL_NOCRC    12
`define CTRL_AUTO     13
// =====================================================================
// Status register fields.
`define ST_ACTIVE     0
`define ST_DONE       1
`define ST_CRC_ERR    2
`define ST_END_ERR    3
`define ST_FRAME_ERR  4
`define ST_ILLEGAL    5
`define ST_TIMEOUT    6
`define ST_DAT_BUSY   7
`define ST_OCR_BUSY   8
`define ST_VWIN_LOW   9
`define ST_IDX_LSB    16
// =====================================================================
// Frame constants and timing.
`define CMD_BITS      8'd48
`define SHORT_BITS    8'd48
`define LONG_BITS     8'd136
`define IDX_ALL_ONES  6'h3F
`define CLKDIV_RESET  8'h04
`define RESP_WAIT     8'd64
`define CRC7_POLY     7'h09
`endif

// ### crc7_unit.v
`timescale 1ns/1ns
// =====================================================================
// Serial CRC7 generator, one bit per enable, polynomial x^7+x^3+1.
module crc7_unit (
  // Clock and reset.
  input  wire       mclk,
  input  wire       resetn,
  // Control.
  input  wire       clear,
  input  wire       shift,
  input  wire       bit_in,
  // Result.
  output reg  [6:0] crc_q
);
  wire fb;
  assign fb = crc_q[6] ^ bit_in;
  always @(posedge mclk) begin
    if (!resetn || clear) begin
      crc_q <= 7'h00;
    end else if (shift) begin
      crc_q <= {crc_q[5:3], crc_q[2] ^ fb, crc_q[1:0], fb};
    end
  end
endmodule // crc7_unit

// ### sd_cmd_host.v
`timescale 1ns/1ns
`include "sd_host_consts.vh"
// Overview of operation
// - Command line serial, MSB first both ways
// - Card opens response with 0,0
// - End bit one; zero flags end error
// - R1b: wait for data line release
// - Card sends register bits 127..1 only
// - Data line low means busy
// - CMD39 argument field layout
// - Card writes only with write flag
// - CMD40 broadcast, answered with
// - CMD42 answered with R1b
// - CMD55 answered marks next app; host marks it whenever CMD55 is sent, answered or not
// - CMD56 bit 0 selects direction
module sd_cmd_host (
  // System clock and reset.
  input  wire        mclk,
  input  wire        resetn,
  // Wishbone slave.
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Card bus.
  output reg         card_clk,
  input  wire        card_command_line_i,
  output reg         card_command_line_o,
  output reg         card_command_line_oe,
  input  wire        card_data_line_i
);
  // ===================================================================
  // States.
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_SEND = 6'b000010;
  localparam [5:0] S_WAIT = 6'b000100;
  localparam [5:0] S_RECV = 6'b001000;
  localparam [5:0] S_BUSY = 6'b010000;
  localparam [5:0] S_GAP  = 6'b100000;

  reg  [5:0]   state_q;
  reg  [13:0]  ctrl_q;
  reg  [31:0]  arg_q;
  reg  [7:0]   div_q;
  reg  [7:0]   divcnt_q;
  reg          cmd_s1_q, cmd_s2_q, dat_s1_q, dat_s2_q;
  reg  [47:0]  tx_q;
  reg  [135:0] rx_q;
  reg  [7:0]   cnt_q;
  reg  [7:0]   rx_len_q;
  reg          done_q, crc_err_q, end_err_q, frm_err_q, ill_q, tmo_q;
  reg          app_q;
  reg  [6:0]   crc_snap_q;
  reg          crc_clr, crc_shift, crc_bit;
  wire [6:0]   crc_val;
  wire         fall, rise;
  wire         wb_req;
  wire [5:0]   idx;
  wire         long_resp, no_crc, reserved_idx, start_req;

  // ===================================================================
  // Shared CRC7 engine, used for both the sent and the received frame.
  crc7_unit u_crc (
    .mclk   (mclk),
    .resetn (resetn),
    .clear  (crc_clr),
    .shift  (crc_shift),
    .bit_in (crc_bit),
    .crc_q  (crc_val)
  );

  // ===================================================================
  // Card clock divider; card clock is parked low at the first divider tick in idle and stays low after it.
  assign fall = card_clk && (divcnt_q == div_q);
  assign rise = !card_clk && (divcnt_q == div_q);
  always @(posedge mclk) begin
    if (!resetn) begin
      divcnt_q <= 8'h00;
      card_clk <= 1'b0;
    end else if (divcnt_q == div_q) begin
      divcnt_q <= 8'h00;
      card_clk <= (state_q == S_IDLE) ? 1'b0 : !card_clk;
    end else begin
      divcnt_q <= divcnt_q + 8'h01;
    end
  end

  // Pin synchronisers.
  always @(posedge mclk) begin
    if (!resetn) begin
      cmd_s1_q <= 1'b1;
      cmd_s2_q <= 1'b1;
      dat_s1_q <= 1'b1;
      dat_s2_q <= 1'b1;
    end else begin
      cmd_s1_q <= card_command_line_i;
      cmd_s2_q <= cmd_s1_q;
      dat_s1_q <= card_data_line_i;
      dat_s2_q <= dat_s1_q;
    end
  end

  // ===================================================================
  // Command decode.
  assign idx       = ctrl_q[`CTRL_IDX_LSB+5:`CTRL_IDX_LSB];
  assign long_resp = (ctrl_q[`CTRL_AUTO] && (idx == 6'd2 || idx == 6'd9 || idx == 6'd10))
                     || ctrl_q[`CTRL_LONG];
  assign no_crc    = (ctrl_q[`CTRL_AUTO] && idx == 6'd1) || ctrl_q[`CTRL_NOCRC];
  assign reserved_idx = (idx == 6'd41) || (idx >= 6'd43 && idx <= 6'd54)
                        || (idx >= 6'd57);
  // The start pulse lands a cycle after the write, once the new index stands.
  assign start_req = ctrl_q[`CTRL_START];

  // ===================================================================
  // Wishbone slave: one wait state, ack for one cycle.
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always @(posedge mclk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_q   <= 14'h0000;
      arg_q    <= 32'h0000_0000;
      div_q    <= `CLKDIV_RESET;
    end else begin
      wb_ack_o <= wb_req;
      ctrl_q[`CTRL_START] <= 1'b0;
      // Writes are only taken while idle, so a running frame keeps its settings.
      if (wb_req && wb_we_i && state_q == S_IDLE) begin
        case (wb_adr_i)
          `REG_CTRL: begin
            if (wb_sel_i[0]) ctrl_q[7:0]  <= wb_dat_i[7:0];
            if (wb_sel_i[1]) ctrl_q[13:8] <= wb_dat_i[13:8];
          end
          `REG_ARG: begin
            if (wb_sel_i[0]) arg_q[7:0]   <= wb_dat_i[7:0];
            if (wb_sel_i[1]) arg_q[15:8]  <= wb_dat_i[15:8];
            if (wb_sel_i[2]) arg_q[23:16] <= wb_dat_i[23:16];
            if (wb_sel_i[3]) arg_q[31:24] <= wb_dat_i[31:24];
          end
          `REG_CLKDIV: begin
            if (wb_sel_i[0]) div_q <= wb_dat_i[7:0];
          end
          default: begin
          end
        endcase
      end
      if (wb_req) begin
        case (wb_adr_i)
          `REG_CTRL:   wb_dat_o <= {18'h00000, ctrl_q};
          `REG_ARG:    wb_dat_o <= arg_q;
          `REG_STATUS: wb_dat_o <= {10'h000, long_resp ? rx_q[133:128] : rx_q[45:40],
                                    6'h00, rx_q[39],
                                    !rx_q[39], !dat_s2_q, tmo_q, ill_q, frm_err_q,
                                    end_err_q, crc_err_q, done_q, state_q != S_IDLE};
          `REG_RESP0:  wb_dat_o <= long_resp ? rx_q[32:1] : rx_q[39:8];
          `REG_RESP1:  wb_dat_o <= long_resp ? rx_q[64:33] : {25'h0, rx_q[7:1]};
          `REG_RESP2:  wb_dat_o <= long_resp ? rx_q[96:65] : 32'h0000_0000;
          `REG_RESP3:  wb_dat_o <= long_resp ? {1'b0, rx_q[127:97]} : 32'h0000_0000;
          `REG_CLKDIV: wb_dat_o <= {24'h000000, div_q};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ===================================================================
  // CRC engine feed, combinational.
  always @* begin
    crc_clr   = 1'b0;
    crc_shift = 1'b0;
    crc_bit   = 1'b0;
    case (state_q)
      S_IDLE: crc_clr = 1'b1;
      S_SEND: begin
        crc_shift = fall && cnt_q < 8'd40;
        crc_bit   = tx_q[47];
        crc_clr   = fall && cnt_q == 8'd47;
      end
      S_RECV: begin
        crc_shift = rise && !(long_resp && cnt_q < 8'd8)
                    && cnt_q < rx_len_q - 8'd8;
        crc_bit   = cmd_s2_q;
      end
      default: crc_clr = 1'b0;
    endcase
  end

  // ===================================================================
  // Frame sequencer. Bits change on the falling card clock edge and are
  // sampled on the rising one.
  always @(posedge mclk) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      tx_q    <= 48'h0000_0000_0000;
      rx_q    <= 136'h0;
      cnt_q   <= 8'h00;
      rx_len_q <= `SHORT_BITS;
      card_command_line_o  <= 1'b1;
      card_command_line_oe <= 1'b0;
      done_q     <= 1'b0;
      crc_err_q  <= 1'b0;
      end_err_q  <= 1'b0;
      frm_err_q  <= 1'b0;
      ill_q      <= 1'b0;
      tmo_q      <= 1'b0;
      app_q      <= 1'b0;
      crc_snap_q <= 7'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          card_command_line_oe <= 1'b0;
          card_command_line_o  <= 1'b1;
          if (start_req) begin
            done_q    <= 1'b0;
            crc_err_q <= 1'b0;
            end_err_q <= 1'b0;
            frm_err_q <= 1'b0;
            tmo_q     <= 1'b0;
            if (reserved_idx && !app_q) begin
              ill_q  <= 1'b1;
              done_q <= 1'b1;
            end else begin
              ill_q   <= 1'b0;
              app_q   <= (idx == 6'd55);
              tx_q    <= {2'b01, idx, arg_q, 8'h00};
              cnt_q   <= 8'h00;
              rx_len_q <= long_resp ? `LONG_BITS : `SHORT_BITS;
              state_q <= S_SEND;
            end
          end
        end
        S_SEND: if (fall) begin
          card_command_line_oe <= 1'b1;
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'd40) begin
            card_command_line_o <= crc_val[6];
            tx_q <= {crc_val[5:0], 1'b1, 41'h0};
          end else begin
            card_command_line_o <= tx_q[47];
            tx_q <= {tx_q[46:0], 1'b0};
          end
          if (cnt_q == 8'd48) begin
            card_command_line_oe <= 1'b0;
            card_command_line_o  <= 1'b1;
            cnt_q <= 8'h00;
            state_q <= ctrl_q[`CTRL_RESP_EN] ? S_WAIT : S_GAP;
          end
        end
        // No start bit within the wait window ends the command as a timeout.
        S_WAIT: if (rise) begin
          cnt_q <= cnt_q + 8'h01;
          if (!cmd_s2_q) begin
            rx_q  <= 136'h0;
            cnt_q <= 8'h01;
            state_q <= S_RECV;
          end else if (cnt_q == `RESP_WAIT) begin
            tmo_q   <= 1'b1;
            done_q  <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_RECV: if (rise) begin
          rx_q  <= {rx_q[134:0], cmd_s2_q};
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == rx_len_q - 8'd8) crc_snap_q <= crc_val;
          if (cnt_q == 8'd1 && cmd_s2_q) frm_err_q <= 1'b1;
          if (cnt_q == rx_len_q - 8'd1) begin
            // These checks see the register before its last shift, one place lower.
            end_err_q <= !cmd_s2_q;
            if (!no_crc && rx_q[6:0] != crc_snap_q) crc_err_q <= 1'b1;
            if (long_resp && rx_q[132:127] != `IDX_ALL_ONES) frm_err_q <= 1'b1;
            if (!long_resp && !no_crc && rx_q[44:39] != idx) frm_err_q <= 1'b1;
            if (no_crc && rx_q[44:39] != `IDX_ALL_ONES) frm_err_q <= 1'b1;
            state_q <= ctrl_q[`CTRL_BUSY_EN] ? S_BUSY : S_GAP;
          end
        end
        // The card holds the data line low while busy; wait for its release.
        S_BUSY: if (rise && dat_s2_q) state_q <= S_GAP;
        S_GAP: if (rise) begin
          done_q  <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // sd_cmd_host

// ### sd_cmd_host_props.sv
`timescale 1ns/1ns
// =====================================================================
// Port checks.
module sd_cmd_host_props (
  input wire mclk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire card_clk,
  input wire card_command_line_o,
  input wire card_command_line_oe
);
  reg       clk_q;
  reg [7:0] bits_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Counts card clock rises while the host drives the line.
  always @(posedge mclk) begin
    clk_q <= card_clk;
    if (!resetn || !card_command_line_oe) bits_q <= 8'h00;
    else if (card_clk && !clk_q) bits_q <= bits_q + 8'h01;
  end
  property p_start_bit;
    $rose(card_command_line_oe) |-> !card_command_line_o;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("frame opened without start bit");
  property p_end_bit;
    $fell(card_command_line_oe) |-> $past(card_command_line_o);
  endproperty
  a_end_bit: assert property (p_end_bit)
    else $error("frame closed without end bit");
  property p_frame_len;
    $fell(card_command_line_oe) |-> bits_q == 8'd48;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("command frame not 48 bits");
  property p_bit_stable;
    card_command_line_oe && $past(card_command_line_oe) && $changed(card_command_line_o)
      |-> !card_clk;
  endproperty
  a_bit_stable: assert property (p_bit_stable)
    else $error("command bit changed while card clock high");
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("bus request not answered next cycle");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  property p_ack_cyc;
    wb_ack_o |-> wb_cyc_i && wb_stb_i;
  endproperty
  a_ack_cyc: assert property (p_ack_cyc)
    else $error("ack without request");
  property p_reset;
    disable iff (1'b0) !resetn |=> !wb_ack_o && !card_command_line_oe && !card_clk;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not idle after reset");
endmodule // sd_cmd_host_props

// ### sd_card_model.sv
`timescale 1ns/1ns
// =====================================================================
// Behavioural card: takes a command and answers in its layout.
module sd_card_model (
  // Card bus.
  input  wire clk,
  input  wire cmd,
  output reg  cmd_o,
  output reg  cmd_oe,
  output reg  dat
);
  integer       dly, busy_ns, n_cmd, i, len;
  reg           bad_crc, bad_end, no_resp, cmd_ok;
  reg  [31:0]   word, got_arg;
  reg  [127:0]  regv;
  reg  [5:0]    got_idx;
  reg  [47:0]   c;
  reg  [135:0]  r;
  reg  [7:0]    fio [0:127];
  function automatic logic [6:0] crc7(input logic [127:0] d, input integer n);
    logic [6:0] v;
    integer     k;
    v = 7'h00;
    for (k = n - 1; k >= 0; k = k - 1)
      v = {v[5:0], 1'b0} ^ ((d[k] ^ v[6]) ? 7'h09 : 7'h00);
    return v;
  endfunction
  initial begin
    cmd_o = 1'b1;
    cmd_oe = 1'b0;
    dat = 1'b1;
    n_cmd = 0;
    for (i = 0; i < 128; i = i + 1) fio[i] = 8'h00;
    forever begin
      @(posedge clk);
      if (cmd === 1'b0 && !cmd_oe) begin
        c[47] = 1'b0;
        for (i = 46; i >= 0; i = i - 1) begin
          @(posedge clk);
          c[i] = cmd;
        end
        got_idx = c[45:40];
        got_arg = c[39:8];
        cmd_ok = c[46] && c[0] && crc7(c[47:8], 40) == c[7:1];
        n_cmd = n_cmd + 1;
        len = 48;
        if (got_idx == 6'd1) r[47:0] = {2'b00, 6'h3F, word, 7'h7F, 1'b1};
        else if (got_idx == 6'd2 || got_idx == 6'd9 || got_idx == 6'd10) begin
          len = 136;
          r = {2'b00, 6'h3F, regv[127:8], crc7(regv[127:8], 120), 1'b1};
        end else if (got_idx == 6'd39) begin
          if (got_arg[15]) fio[got_arg[14:8]] = got_arg[7:0];
          r[47:0] = {2'b00, 6'h3F, got_arg[31:16], 1'b0, got_arg[14:8], fio[got_arg[14:8]],
            7'h7F, 1'b1};
        end else r[47:0] = {2'b00, got_idx, word, crc7({2'b00, got_idx, word}, 40), 1'b1};
        r[1] = r[1] ^ bad_crc;
        r[0] = !bad_end;
        if (!no_resp) begin
          repeat (dly) @(negedge clk);
          for (i = len - 1; i >= 0; i = i - 1) begin
            cmd_o = r[i];
            cmd_oe = 1'b1;
            @(negedge clk);
          end
          cmd_oe = 1'b0;
          if (busy_ns > 0) begin
            dat = 1'b0;
            #(busy_ns);
            dat = 1'b1;
          end
        end
      end
    end
  end
endmodule // sd_card_model

// ### sd_cmd_host_tb.sv
`timescale 1ns/1ns
`include "sd_host_consts.vh"
// =====================================================================
// Bench: bus master, card model and result checks.
module sd_cmd_host_tb;
  reg         mclk, resetn, cyc, stb, we, after55;
  reg  [7:0]  adr;
  reg  [3:0]  sel;
  reg  [31:0] wdat, q, arg, st, ex, mk;
  reg  [7:0]  fio_t;
  wire [31:0] rdat;
  wire        ack, card_clk, h_o, h_oe, c_o, c_oe, dat, cmd_w;
  integer     err_count, num_checks, seed, n0, k;
  integer     rl [0:4] = '{41, 43, 54, 57, 63};
  // Pulled-up command line.
  assign cmd_w = h_oe ? h_o : (c_oe ? c_o : 1'b1);
  sd_cmd_host DUT (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .card_clk(card_clk), .card_command_line_i(cmd_w),
    .card_command_line_o(h_o), .card_command_line_oe(h_oe), .card_data_line_i(dat));
  sd_card_model card (.clk(card_clk), .cmd(cmd_w), .cmd_o(c_o), .cmd_oe(c_oe), .dat(dat));
  always #50 mclk = !mclk;
  task chk(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) begin
      @(posedge mclk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // f: bit0 bad CRC, bit1 bad end bit, bit2 no answer.
  task op(input integer i, input integer f);
    reg [5:0] idx;
    reg       resv, lng, r3;
    reg [31:0] ew;
    integer   n;
    idx = i[5:0];
    resv = !after55 && (i == 41 || (i >= 43 && i <= 54) || i >= 57);
    lng = i == 2 || i == 9 || i == 10;
    r3 = i == 1 || i == 39;
    arg = $random(seed);
    if (i == 39) arg[15:8] = {f[3], 7'h15};
    card.word = $random(seed);
    ew = card.word;
    if (i == 39) begin
      if (f[3]) fio_t = arg[7:0];
      ew = {arg[31:16], 1'b0, arg[14:8], fio_t};
    end
    card.regv = {$random(seed), $random(seed), $random(seed), $random(seed)};
    card.dly = 2 + ({$random(seed)} % 30);
    {card.no_resp, card.bad_end, card.bad_crc} = f[2:0];
    card.busy_ns = (i == 42) ? 20000 : 0;
    n0 = card.n_cmd;
    wb(1'b1, `REG_ARG, arg);
    wb(1'b1, `REG_CTRL, 32'h2300 | {26'h0, idx} | {21'h0, i == 42, 10'h0}
      | {19'h0, i == 39, 12'h0});
    st = 32'h0;
    n = 0;
    while (st[1] !== 1'b1 && n < 3000) begin
      wb(1'b0, `REG_STATUS, 32'h0);
      st = q;
      n = n + 1;
    end
    ex = {10'h0, (resv || f[2]) ? 6'h0 : (lng || r3) ? 6'h3F : idx, 9'h0, f[2], resv,
      1'b0, f[1], f[0] && !r3, 2'b10};
    mk = (resv || f[2]) ? 32'hFF : 32'h003F00FF;
    chk(st & mk, ex & mk);
    if (i == 1) chk(st[9:8], {ew[31], !ew[31]});
    if (resv) chk(card.n_cmd, n0);
    else begin
      chk(card.got_idx, idx);
      chk(card.got_arg, arg);
      chk(card.cmd_ok, 1);
    end
    if (!resv && !f[2] && !lng) begin
      wb(1'b0, `REG_RESP0, 32'h0);
      chk(q, ew);
    end
    if (lng) begin
      wb(1'b0, `REG_RESP3, 32'h0);
      chk(q, {1'b0, card.regv[127:97]});
    end
    chk(dat, 1);
    after55 = i == 55;
    $display("test cmd %0d done", i);
  endtask
  initial begin
    {mclk, resetn, cyc, stb, we, after55, adr, wdat} = 0;
    sel = 4'hF;
    fio_t = 8'h00;
    err_count = 0;
    num_checks = 0;
    seed = 32'h63b1;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    wb(1'b0, `REG_CLKDIV, 32'h0);
    chk(q, {24'h0, `CLKDIV_RESET});
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    $display("test registers done");
    op(17, 0);
    op(13, 1);
    op(24, 2);
    op(1, 1);
    op(2, 0);
    op(9, 0);
    op(10, 0);
    op(42, 0);
    op(13, 4);
    for (k = 0; k < 5; k = k + 1) op(rl[k], 0);
    op(55, 0);
    op(41, 0);
    op(56, 0);
    op(39, 8);
    op(39, 0);
    give_verdict;
  end
  initial begin
    #(9000000);
    err_count = err_count + 1;
    give_verdict;
  end
endmodule // sd_cmd_host_tb
bind sd_cmd_host sd_cmd_host_props u_props (.mclk(mclk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .card_clk(card_clk),
  .card_command_line_o(card_command_line_o), .card_command_line_oe(card_command_line_oe));
